// *** pkg/ebfc_pkg.sv ***
// Package for the extended bus and filter configuration block.
// Assumes an APB slave with 32-bit data and one register word per index.
package ebfc_pkg;
    // Register indices; byte address is index times four
    localparam logic [7:0]  CFG_INDEX      = 8'h3f;
    localparam logic [11:0] CFG_ADDR       = 12'h0fc;
    localparam logic [11:0] STATUS_ADDR    = 12'h100;
    // Field positions of the configuration word
    localparam int          LEVEL_LSB      = 12;
    localparam int          HOLD_EDGE_BIT  = 4;
    localparam int          ON_MATCH_BIT   = 2;
    localparam int          ON_MISS_BIT    = 1;
    localparam int          REJECT_BIT     = 0;
    // Writable bits; 11..5 and 3 are forced to zero
    localparam logic [15:0] CFG_WR_MASK    = 16'hf017;
    localparam logic [15:0] CFG_RESET      = 16'h0000;
    localparam logic [31:0] UNMAPPED_DATA  = 32'h0000_0000;

    typedef struct packed {
        logic [3:0] ext_out_level;
        logic       hold_edge_select;
        logic       compress_on_match;
        logic       compress_on_miss;
        logic       reject_on_match;
    } ebfc_cfg_t;

    typedef struct packed {
        logic pkt_start;
        logic addr_valid;
        logic cam_hit;
        logic broadcast;
        logic bcast_ok;
        logic phys_ok;
        logic mcast_ok;
    } ebfc_rx_t;
endpackage : ebfc_pkg

// *** src/ebfc_top.sv ***
// Extended bus and filter configuration register with its side logic.
// Assumes APB master on clk_in, and receive events synchronous to clk_in.
// Assumes the hard reset is the only reset that reaches the register.
`timescale 1ns/10ps
`default_nettype none
module ebfc_top (
    input  wire logic             clk_in,
    input  wire logic             sys_rst_in,
    input  wire logic             psel_in,
    input  wire logic             penable_in,
    input  wire logic             pwrite_in,
    input  wire logic [11:0]      paddr_in,
    input  wire logic [31:0]      pwdata_in,
    output var  logic [31:0]      prdata_out,
    output var  logic             pready_out,
    output var  logic             pslverr_out,
    input  wire logic             bus_master_in,
    input  wire logic             ext_bus_mode_in,
    input  wire logic             hold_req_in,
    input  wire ebfc_pkg::ebfc_rx_t rx_in,
    output var  logic [3:0]       ext_user_out,
    output var  logic [3:0]       ext_user_oe_out,
    output var  logic             hold_out,
    output var  logic             packet_compress_out,
    output var  logic             packet_compress_oe_out,
    output var  logic             accept_out,
    output var  logic             accept_valid_out
);
    // Register fields and the state behind the side outputs
    ebfc_pkg::ebfc_cfg_t cfg;
    ebfc_pkg::ebfc_cfg_t next_cfg;
    logic                hold_neg;
    logic                hold_rise;
    logic                compress;
    logic                accept;
    logic [31:0]         next_rdata;
    logic                next_pready;
    logic                next_pslverr;
    logic                next_compress;
    logic                next_accept;
    logic                next_accept_valid;
    logic                next_packet_compress;
    logic                next_compress_oe;
    logic [3:0]          next_ext_user;
    logic [3:0]          next_ext_user_oe;

    // Packs the register fields into the readable word
    function automatic logic [15:0] cfg_word(
        input ebfc_pkg::ebfc_cfg_t c
    );
        cfg_word = {c.ext_out_level, 7'h00, c.hold_edge_select, 1'b0,
                    c.compress_on_match, c.compress_on_miss,
                    c.reject_on_match};
    endfunction : cfg_word

    // Unpacks a masked write word into the register fields
    function automatic ebfc_pkg::ebfc_cfg_t cfg_fields(
        input logic [15:0] w
    );
        cfg_fields.ext_out_level     = w[ebfc_pkg::LEVEL_LSB +: 4];
        cfg_fields.hold_edge_select  = w[ebfc_pkg::HOLD_EDGE_BIT];
        cfg_fields.compress_on_match = w[ebfc_pkg::ON_MATCH_BIT];
        cfg_fields.compress_on_miss  = w[ebfc_pkg::ON_MISS_BIT];
        cfg_fields.reject_on_match   = w[ebfc_pkg::REJECT_BIT];
    endfunction : cfg_fields

    // True when the bus address selects the given register word
    function automatic logic addr_hit(
        input logic [11:0] addr,
        input logic [11:0] target
    );
        addr_hit = addr == target;
    endfunction : addr_hit

    // CAM result; the reject bit turns a match into a refusal
    function automatic logic cam_accept(
        input ebfc_pkg::ebfc_cfg_t c,
        input ebfc_pkg::ebfc_rx_t  r
    );
        cam_accept = r.cam_hit & ~c.reject_on_match;
    endfunction : cam_accept

    // Accept bits act on their own, never through the reject bit
    function automatic logic other_accept(
        input ebfc_pkg::ebfc_rx_t r
    );
        other_accept = (r.broadcast & r.bcast_ok) | r.phys_ok |
                       r.mcast_ok;
    endfunction : other_accept

    // Compress decision for one packet; broadcasts never compress
    function automatic logic compress_pick(
        input ebfc_pkg::ebfc_cfg_t c,
        input ebfc_pkg::ebfc_rx_t  r
    );
        logic on_hit;
        logic on_miss;
        on_hit  = c.compress_on_match & ~c.compress_on_miss &
                  r.cam_hit;
        on_miss = c.compress_on_miss & ~c.compress_on_match &
                  ~r.cam_hit;
        compress_pick = (on_hit | on_miss) & ~r.broadcast;
    endfunction : compress_pick

    // Level bits reach the pins only while driving in extended mode
    function automatic logic [3:0] user_levels(
        input logic                drive,
        input ebfc_pkg::ebfc_cfg_t c
    );
        user_levels = drive ? c.ext_out_level : 4'h0;
    endfunction : user_levels

    // APB decode; the answer comes in the first access cycle
    wire        setup_phase  = psel_in & ~penable_in;
    wire        access_phase = psel_in & penable_in;
    wire        hit_cfg      = addr_hit(paddr_in, ebfc_pkg::CFG_ADDR);
    wire        hit_stat     = addr_hit(paddr_in, ebfc_pkg::STATUS_ADDR);
    wire        mapped       = hit_cfg | hit_stat;
    wire        wr_cfg       = access_phase & pwrite_in & hit_cfg;
    wire [15:0] wr_word      = pwdata_in[15:0] &
                               ebfc_pkg::CFG_WR_MASK;
    // Status word: compress, last accept, hold, compress enable
    wire [3:0]  status_bits  = {compress, accept, hold_out,
                                packet_compress_oe_out};
    wire        drive_user   = bus_master_in & ext_bus_mode_in;
    wire        rx_accept    = cam_accept(cfg, rx_in) |
                               other_accept(rx_in);

    // Next values of the registered outputs
    assign next_cfg             = cfg_fields(wr_word);
    assign next_rdata           = hit_cfg  ? {16'h0000, cfg_word(cfg)} :
                                  hit_stat ? {28'h0000000, status_bits} :
                                  ebfc_pkg::UNMAPPED_DATA;
    assign next_pready          = setup_phase;
    assign next_pslverr         = setup_phase & ~mapped;
    assign next_compress        = compress_pick(cfg, rx_in);
    assign next_accept          = rx_in.addr_valid ? rx_accept : accept;
    assign next_accept_valid    = rx_in.addr_valid;
    assign next_packet_compress = rx_in.pkt_start  ? 1'b0 :
                                  rx_in.addr_valid ? next_compress :
                                  compress;
    assign next_ext_user        = user_levels(drive_user, cfg);
    assign next_ext_user_oe     = {4{drive_user}};
    assign next_compress_oe     = cfg.compress_on_match |
                                  cfg.compress_on_miss;

    // APB slave
    // Only the hard reset touches the register
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cfg <= '0;
        end else if (wr_cfg) begin
            cfg <= next_cfg;
        end
    end

    // Read data captured in the setup cycle
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (setup_phase) begin
            prdata_out <= next_rdata;
        end
    end

    // One-cycle ready in the first access cycle
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pready_out <= 1'b0;
        end else begin
            pready_out <= next_pready;
        end
    end

    // Error flag for unmapped addresses
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pslverr_out <= 1'b0;
        end else begin
            pslverr_out <= next_pslverr;
        end
    end

    // Hold request timing
    // Falling-edge copy of the hold request
    always_ff @(negedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            hold_neg <= 1'b0;
        end else begin
            hold_neg <= hold_req_in;
        end
    end

    // Same request half a clock later
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            hold_rise <= 1'b0;
        end else begin
            hold_rise <= hold_neg;
        end
    end

    // Mux between two flops so the pin can move on either edge
    always_comb begin
        hold_out = cfg.hold_edge_select ? hold_rise : hold_neg;
    end

    // User outputs
    // Programmed levels
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ext_user_out <= 4'h0;
        end else begin
            ext_user_out <= next_ext_user;
        end
    end

    // Pins driven only while master in extended mode
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ext_user_oe_out <= 4'h0;
        end else begin
            ext_user_oe_out <= next_ext_user_oe;
        end
    end

    // Receive side
    // Compress state, cleared as each packet starts
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            compress <= 1'b0;
        end else if (rx_in.pkt_start) begin
            compress <= 1'b0;
        end else if (rx_in.addr_valid) begin
            compress <= next_compress;
        end
    end

    // Compress pin level
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            packet_compress_out <= 1'b0;
        end else begin
            packet_compress_out <= next_packet_compress;
        end
    end

    // Compress pin floats while both compress modes are off
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            packet_compress_oe_out <= 1'b0;
        end else begin
            packet_compress_oe_out <= next_compress_oe;
        end
    end

    // Last accept decision, kept for the status word
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            accept <= 1'b0;
        end else begin
            accept <= next_accept;
        end
    end

    // Accept decision pin
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            accept_out <= 1'b0;
        end else begin
            accept_out <= next_accept;
        end
    end

    // One-cycle strobe after each address compare
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            accept_valid_out <= 1'b0;
        end else begin
            accept_valid_out <= next_accept_valid;
        end
    end
endmodule : ebfc_top
`default_nettype wire

// *** tb/ebfc_host.sv ***
// APB host model: one transfer per call of xfer.
// Assumes an APB slave on clk_in; waits for pready_in.
`timescale 1ns/10ps
`default_nettype none
module ebfc_host (
    input  wire logic        clk_in,
    output var  logic        psel_out,
    output var  logic        penable_out,
    output var  logic        pwrite_out,
    output var  logic [11:0] paddr_out,
    output var  logic [31:0] pwdata_out,
    input  wire logic [31:0] prdata_in,
    input  wire logic        pready_in,
    input  wire logic        pslverr_in
);
    initial {psel_out, penable_out, pwrite_out, paddr_out, pwdata_out} = '0;
    // Callers keep reserved bits and dual compress modes clear
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge clk_in);
        psel_out <= 1'b1;
        pwrite_out <= w;
        paddr_out <= a;
        pwdata_out <= d;
        @(posedge clk_in) penable_out <= 1'b1;
        do @(posedge clk_in); while (pready_in !== 1'b1);
        q = prdata_in;
        e = pslverr_in;
        psel_out <= 1'b0;
        penable_out <= 1'b0;
        pwdata_out <= ~d;
    endtask : xfer
endmodule : ebfc_host
`default_nettype wire

// *** tb/ebfc_sva.sv ***
// Port checker for the config block.
// Assumes bound to ebfc_top; receive events sync to clk_in.
`timescale 1ns/10ps
`default_nettype none
module ebfc_sva (
    input wire logic               clk_in,
    input wire logic               sys_rst_in,
    input wire logic               bus_master_in,
    input wire logic               ext_bus_mode_in,
    input wire logic               hold_req_in,
    input wire ebfc_pkg::ebfc_rx_t rx_in,
    input wire logic [3:0]         ext_user_oe_out,
    input wire logic               hold_out,
    input wire logic               packet_compress_out,
    input wire logic               accept_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    user_on_a: assert property (bus_master_in && ext_bus_mode_in |=>
        ext_user_oe_out == 4'hf) else $error("user pins idle");
    mode_off_a: assert property (!ext_bus_mode_in |=>
        ext_user_oe_out == 4'h0) else $error("user pins driven");
    master_off_a: assert property (!bus_master_in |=>
        ext_user_oe_out == 4'h0) else $error("user pins driven");
    hold_hi_a: assert property (hold_req_in [*3] |=> hold_out)
        else $error("hold not raised");
    hold_lo_a: assert property (!hold_req_in [*3] |=> !hold_out)
        else $error("hold not dropped");
    bcast_nc_a: assert property (rx_in.addr_valid && rx_in.broadcast
        |=> !packet_compress_out) else $error("broadcast compressed");
    start_nc_a: assert property (rx_in.pkt_start
        |=> !packet_compress_out) else $error("compress kept");
    bcast_acc_a: assert property (rx_in.addr_valid && rx_in.broadcast
        && rx_in.bcast_ok |=> accept_out) else $error("broadcast lost");
endmodule : ebfc_sva
bind ebfc_top ebfc_sva u_sva (.clk_in, .sys_rst_in, .bus_master_in,
    .ext_bus_mode_in, .hold_req_in, .rx_in, .ext_user_oe_out, .hold_out,
    .packet_compress_out, .accept_out);
`default_nettype wire

// *** tb/tb.sv ***
// Bench: host model on APB, bench drives receive and hold inputs.
// Assumes registered receive outputs one cycle after addr_valid.
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk_in = 0, sys_rst_in = 1, bus_master_in = 0, e;
    logic ext_bus_mode_in = 0, hold_req_in = 0;
    ebfc_pkg::ebfc_rx_t rx_in = '0;
    logic psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
    logic [11:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, q;
    logic [3:0] ext_user_out, ext_user_oe_out;
    logic hold_out, packet_compress_out, packet_compress_oe_out;
    logic accept_out, accept_valid_out;
    int mismatches = 0, total_checks = 0, cyc = 0;
    ebfc_top dut (.*);
    ebfc_host host (.clk_in, .psel_out(psel_in), .penable_out(penable_in),
        .pwrite_out(pwrite_in), .paddr_out(paddr_in), .pwdata_out(pwdata_in),
        .prdata_in(prdata_out), .pready_in(pready_out),
        .pslverr_in(pslverr_out));
    always #2.5 clk_in = ~clk_in;
    always @(posedge clk_in) if (++cyc == 3000) begin
        mismatches++;
        end_of_test();
    end
    task automatic chk(input logic [31:0] g, x);
        total_checks++;
        if (g !== x) begin
            mismatches++;
            $display("unexpected at %0t: got %h exp %h", $time, g, x);
        end
    endtask : chk
    task automatic pkt(input logic c, b);
        @(posedge clk_in) rx_in <= 7'h40;
        @(posedge clk_in) rx_in <= {2'b01, c, b, b, 2'b00};
        @(posedge clk_in) rx_in <= '0;
        #1;
    endtask : pkt
    task automatic t_regs;
        host.xfer(1'b0, ebfc_pkg::CFG_ADDR, 32'h0, q, e);
        chk(q, 32'h0);
        host.xfer(1'b1, ebfc_pkg::CFG_ADDR, 32'h0000_f013, q, e);
        host.xfer(1'b0, ebfc_pkg::CFG_ADDR, 32'h0, q, e);
        chk(q, 32'h0000_f013);
        host.xfer(1'b0, 12'h200, 32'h0, q, e);
        chk({q[30:0], e}, 32'h1);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_pins;
        @(posedge clk_in) {bus_master_in, ext_bus_mode_in} <= 2'b11;
        hold_req_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        #1 chk({ext_user_out, hold_out}, 5'h1f);
        @(posedge clk_in) ext_bus_mode_in <= 1'b0;
        hold_req_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        #1 chk({ext_user_out, hold_out}, 5'h0);
        $display("t_pins done");
    endtask : t_pins
    task automatic t_filt;
        pkt(1'b0, 1'b0);
        chk({packet_compress_out, accept_out, accept_valid_out}, 3'b101);
        pkt(1'b1, 1'b1);
        chk({packet_compress_out, accept_out}, 2'b01);
        pkt(1'b1, 1'b0);
        chk(accept_out, 1'b0);
        host.xfer(1'b1, ebfc_pkg::CFG_ADDR, 32'h4, q, e);
        pkt(1'b1, 1'b0);
        chk({packet_compress_oe_out, packet_compress_out}, 2'b11);
        host.xfer(1'b0, ebfc_pkg::STATUS_ADDR, 32'h0, q, e);
        chk(q, 32'hd);
        host.xfer(1'b1, ebfc_pkg::CFG_ADDR, 32'h0, q, e);
        @(posedge clk_in) #1 chk(packet_compress_oe_out, 1'b0);
        $display("t_filt done");
    endtask : t_filt
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (8) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        t_regs();
        t_pins();
        t_filt();
        end_of_test();
    end
endmodule : tb
`default_nettype wire
